/* File: include/toc_pkg.sv */
// Constants shared by the timer output compare unit
package toc_pkg;
  localparam int NCH = 3;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 4;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_ACTION = 4'h1;
  localparam logic [3:0] REG_FORCE = 4'h2;
  localparam logic [3:0] REG_IRQ_EN = 4'h3;
  localparam logic [3:0] REG_FLAGS = 4'h4;
  localparam logic [3:0] REG_CNT_LO = 4'h5;
  localparam logic [3:0] REG_CNT_HI = 4'h6;
  localparam logic [3:0] REG_CAP_LO = 4'h7;
  localparam logic [3:0] REG_CAP_HI = 4'h8;
  localparam logic [3:0] REG_CMP_LO [NCH] = '{4'h9, 4'hb, 4'hd};
  localparam logic [3:0] REG_CMP_HI [NCH] = '{4'ha, 4'hc, 4'he};
  localparam logic [3:0] REG_PORT = 4'hf;

  // Field positions
  localparam int FLAG_CAP_BIT = 3;
  localparam int PORT_DATA_LSB = 4;
  localparam int ACT_W = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Waveform mode codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLEAR_A = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_CLEAR_CAP = 4'hc;
  localparam logic [3:0] MODE_RESERVED = 4'hd;
  localparam logic [3:0] MODE_FAST_CAP = 4'he;
  localparam logic [3:0] MODE_FAST_A = 4'hf;

  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Counter limits
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8 = 16'h00ff;
  localparam logic [15:0] TOP_9 = 16'h01ff;
  localparam logic [15:0] TOP_10 = 16'h03ff;
endpackage

/* File: hdl/toc_compare_unit.sv */
// Output compare channels, capture register and counter of a 16-bit timer
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module toc_compare_unit
  import toc_pkg::*;
(
  // Clock, reset, clock enable
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Timer clock tick, one core cycle wide
  input wire logic i_tick,
  // Capture event, already edge-detected
  input wire logic i_capture_event,
  // Interrupt service acknowledge per channel
  input wire logic [NCH-1:0] i_irq_ack,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [BYTE_W-1:0] i_avs_writedata,
  output logic [BYTE_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt requests and pins
  output logic [NCH-1:0] o_cmp_irq,
  output logic [NCH-1:0] o_pin_out,
  output logic [NCH-1:0] o_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // Modes 1-3, 5-11, 14 and 15 are the PWM modes
  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !(m == MODE_NORMAL || m == MODE_CLEAR_A || m == MODE_CLEAR_CAP ||
               m == MODE_RESERVED);
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == MODE_CLEAR_CAP || m == MODE_FAST_CAP);
  endfunction

  function automatic logic [15:0] top_value(input logic [3:0] m,
                                            input logic [15:0] cmp_a,
                                            input logic [15:0] cap);
    case (m)
      MODE_CLEAR_A, MODE_FAST_A: top_value = cmp_a;
      MODE_CLEAR_CAP, MODE_FAST_CAP: top_value = cap;
      MODE_FAST8: top_value = TOP_8;
      MODE_FAST9: top_value = TOP_9;
      MODE_FAST10: top_value = TOP_10;
      default: top_value = TOP_MAX;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and internal state
  logic [3:0] mode;
  logic [3*ACT_W-1:0] action;
  logic [NCH-1:0] irq_en;
  logic [NCH-1:0] port_dir;
  logic [NCH-1:0] port_data;
  logic [7:0] temp;
  logic [15:0] counter;
  logic [15:0] capture;
  logic capture_flag;
  logic block;
  logic [15:0] cmp_act [NCH];
  logic [15:0] cmp_buf [NCH];
  logic cmp_flag [NCH];
  logic oc_state [NCH];
  logic [1:0] ch_act [NCH];
  logic wr_go;
  logic rd_go;
  logic pwm;
  logic [15:0] top_now;
  logic at_top;
  logic cnt_wr_go;
  logic [7:0] next_readdata;
  assign wr_go = i_avs_write && !o_avs_waitrequest;
  assign rd_go = i_avs_read && o_avs_waitrequest;
  assign pwm = is_pwm(mode);
  assign top_now = top_value(mode, cmp_act[0], capture);
  assign at_top = (counter == top_now);
  assign cnt_wr_go = wr_go && i_avs_address == REG_CNT_LO;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle on every access
  // Read data loads while waitrequest is high, so it stands when the master sees it low
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else if (i_ce) begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= RST_BYTE;
    end else if (i_ce && i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= next_readdata;
    end
  end
  always_comb begin
    next_readdata = RST_BYTE;
    case (i_avs_address)
      REG_MODE: next_readdata = {4'h0, mode};
      REG_ACTION: next_readdata = {2'h0, action};
      REG_IRQ_EN: next_readdata = {5'h00, irq_en};
      REG_FLAGS: next_readdata = {4'h0, capture_flag, cmp_flag[2], cmp_flag[1], cmp_flag[0]};
      REG_CNT_LO: next_readdata = counter[7:0];
      REG_CNT_HI: next_readdata = temp;
      REG_CAP_LO: next_readdata = capture[7:0];
      REG_CAP_HI: next_readdata = temp;
      REG_PORT: next_readdata = {1'b0, port_data, 1'b0, port_dir};
      default: next_readdata = RST_BYTE;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (i_avs_address == REG_CMP_LO[i]) begin
        next_readdata = pwm ? cmp_buf[i][7:0] : cmp_act[i][7:0];
      end
      if (i_avs_address == REG_CMP_HI[i]) begin
        next_readdata = pwm ? cmp_buf[i][15:8] : cmp_act[i][15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  // Action bits are used straight from here, with no shadow copy
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= 4'h0;
      action <= 6'h00;
      irq_en <= 3'h0;
      port_dir <= 3'h0;
      port_data <= 3'h0;
    end else if (i_ce && wr_go) begin
      case (i_avs_address)
        REG_MODE: mode <= i_avs_writedata[3:0];
        REG_ACTION: action <= i_avs_writedata[5:0];
        REG_IRQ_EN: irq_en <= i_avs_writedata[2:0];
        REG_PORT: begin
          port_dir <= i_avs_writedata[2:0];
          port_data <= i_avs_writedata[PORT_DATA_LSB +: NCH];
        end
        default: ;
      endcase
    end
  end
  // Shared high-byte holding register; a counter or capture low read fills it as its data loads
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      temp <= RST_BYTE;
    end else if (i_ce) begin
      if (wr_go && (i_avs_address == REG_CNT_HI || i_avs_address == REG_CAP_HI ||
                    i_avs_address == REG_CMP_HI[0] || i_avs_address == REG_CMP_HI[1] ||
                    i_avs_address == REG_CMP_HI[2])) begin
        temp <= i_avs_writedata;
      end else if (rd_go && i_avs_address == REG_CNT_LO) begin
        temp <= counter[15:8];
      end else if (rd_go && i_avs_address == REG_CAP_LO) begin
        temp <= capture[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, match blocking and capture
  // Counts up only; the dual-slope modes are treated as single-slope here.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      counter <= RST_WORD;
    end else if (i_ce) begin
      if (cnt_wr_go) begin
        counter <= {temp, i_avs_writedata};
      end else if (i_tick) begin
        if (at_top && mode != MODE_NORMAL) begin
          counter <= RST_WORD;
        end else begin
          counter <= counter + 16'h0001;
        end
      end
    end
  end
  // Held from the write until the next tick, even if ticks are stopped
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      block <= 1'b0;
    end else if (i_ce) begin
      if (cnt_wr_go) begin
        block <= 1'b1;
      end else if (i_tick) begin
        block <= 1'b0;
      end
    end
  end
  // Capture never looks at the action bits
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      capture <= RST_WORD;
    end else if (i_ce) begin
      if (i_capture_event && !cap_is_top(mode)) begin
        capture <= counter;
      end else if (wr_go && i_avs_address == REG_CAP_LO && cap_is_top(mode)) begin
        capture <= {temp, i_avs_writedata};
      end
    end
  end
  // Set wins over a same-cycle clear
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      capture_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_capture_event && !cap_is_top(mode)) begin
        capture_flag <= 1'b1;
      end else if (wr_go && i_avs_address == REG_FLAGS && i_avs_writedata[FLAG_CAP_BIT]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare channels
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic match;
    logic hit;
    logic force_go;
    logic next_oc;
    assign ch_act[g] = action[g*ACT_W +: ACT_W];
    assign match = (counter == cmp_act[g]);
    assign hit = i_tick && match && !block;
    assign force_go = wr_go && i_avs_address == REG_FORCE && i_avs_writedata[g] && !pwm;
    // Compare registers: the low-byte write commits both bytes at once
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        cmp_buf[g] <= RST_WORD;
        cmp_act[g] <= RST_WORD;
      end else if (i_ce) begin
        if (wr_go && i_avs_address == REG_CMP_LO[g]) begin
          cmp_buf[g] <= {temp, i_avs_writedata};
          if (!pwm) begin
            cmp_act[g] <= {temp, i_avs_writedata};
          end
        end
        if (pwm && i_tick && at_top) begin
          cmp_act[g] <= cmp_buf[g];
        end
      end
    end
    // Flag lands on the tick that ends the equal cycle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        cmp_flag[g] <= 1'b0;
      end else if (i_ce) begin
        if (hit) begin
          cmp_flag[g] <= 1'b1;
        end else if (i_irq_ack[g] ||
                     (wr_go && i_avs_address == REG_FLAGS && i_avs_writedata[g])) begin
          cmp_flag[g] <= 1'b0;
        end
      end
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        o_cmp_irq[g] <= 1'b0;
      end else if (i_ce) begin
        o_cmp_irq[g] <= cmp_flag[g] && irq_en[g];
      end
    end
    // Bottom action wins so a compare equal to TOP gives a steady level
    always_comb begin
      next_oc = oc_state[g];
      if (pwm && i_tick && at_top) begin
        if (ch_act[g] == ACT_CLEAR) begin
          next_oc = 1'b1;
        end else if (ch_act[g] == ACT_SET) begin
          next_oc = 1'b0;
        end
      end else if (hit || force_go) begin
        case (ch_act[g])
          ACT_TOGGLE: next_oc = !oc_state[g];
          ACT_CLEAR: next_oc = 1'b0;
          ACT_SET: next_oc = 1'b1;
          default: next_oc = oc_state[g];
        endcase
      end
    end
    // Mode writes never touch this bit
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        oc_state[g] <= 1'b0;
      end else if (i_ce) begin
        oc_state[g] <= next_oc;
      end
    end
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        o_pin_out[g] <= 1'b0;
        o_pin_oe_n[g] <= 1'b1;
      end else if (i_ce) begin
        o_pin_out[g] <= (ch_act[g] != ACT_NONE) ? oc_state[g] : port_data[g];
        o_pin_oe_n[g] <= !port_dir[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0 and the shared logic
  a_capture_overwrite: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_capture_event && !cap_is_top(mode) |=> capture == $past(counter))
    else $error("capture did not take the counter value");
  a_flag_after_tick: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(cmp_flag[0]) |-> $past(i_tick && i_ce && !block && counter == cmp_act[0]))
    else $error("compare flag rose without a matching tick");
  a_irq_request: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && cmp_flag[0] && irq_en[0] |=> o_cmp_irq[0])
    else $error("enabled compare flag gave no interrupt");
  a_buffer_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
    pwm && !(i_tick && at_top) |=> $stable(cmp_act[0]))
    else $error("active compare changed away from TOP");
  a_counter_write_block: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && block && i_tick && !cmp_flag[0] && !cnt_wr_go |=> !cmp_flag[0] && !block)
    else $error("match not blocked in the tick after a counter write");
  a_force_no_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && g_ch[0].force_go && !i_tick && !cmp_flag[0] && ch_act[0] != ACT_NONE
    |=> !cmp_flag[0] && oc_state[0] == (($past(ch_act[0]) == ACT_TOGGLE) ?
                                        !$past(oc_state[0]) : $past(ch_act[0]) == ACT_SET))
    else $error("force set the flag or gave the wrong output state");
  a_match_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_tick && mode == MODE_CLEAR_A && counter == cmp_act[0] && !cnt_wr_go
    |=> counter == RST_WORD)
    else $error("counter not cleared on clear-on-match");
  a_pin_override: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_ce && ch_act[0] != ACT_NONE |=> o_pin_out[0] == $past(oc_state[0]))
    else $error("pin did not show output compare state");
  a_action_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ch_act[0] == ACT_NONE |=> $stable(oc_state[0]))
    else $error("output state moved with action zero");
endmodule
`default_nettype wire

/* File: dv/toc_cpu_model.sv */
// CPU model: Avalon-MM master that reaches the timer's byte registers
`timescale 1ns/1ps
`default_nettype none
module toc_cpu_model
  import toc_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Avalon-MM master side
  output logic [ADDR_W-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [BYTE_W-1:0] o_writedata,
  input wire logic [BYTE_W-1:0] i_readdata,
  input wire logic i_waitrequest
);
  int hangs = 0;
  initial begin
    o_address = '0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One access; the leading edge keeps a release and a new request apart
  task automatic access(input logic [ADDR_W-1:0] a, input logic rd,
                        input logic [BYTE_W-1:0] d, output logic [BYTE_W-1:0] q);
    int n;
    n = 0;
    @(posedge i_core_clk);
    o_address <= a;
    o_read <= rd;
    o_write <= !rd;
    o_writedata <= d;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hangs++;
    q = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    logic [BYTE_W-1:0] q;
    access(a, 1'b0, d, q);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] q);
    access(a, 1'b1, 8'h00, q);
  endtask
  // High byte only fills the holding byte, so it must go first
  task automatic wr16(input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi,
                      input logic [CNT_W-1:0] v);
    wr(hi, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // Low read latches the high byte for the following high read
  task automatic rd16(input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi,
                      output logic [CNT_W-1:0] v);
    rd(lo, v[7:0]);
    rd(hi, v[15:8]);
  endtask
endmodule
`default_nettype wire

/* File: dv/timer16_output_compare_unit_test.sv */
// Self-checking testbench for the timer output compare unit
`timescale 1ns/1ps
`default_nettype none
module timer16_output_compare_unit_test;
  import toc_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_tick = 1'b0;
  logic i_capture_event = 1'b0;
  logic [NCH-1:0] i_irq_ack = '0;
  logic [ADDR_W-1:0] adr;
  logic rd_s, wr_s, wt;
  logic [BYTE_W-1:0] wdat, rdat, q;
  logic [CNT_W-1:0] w;
  logic [NCH-1:0] irq, pin, oe_n;
  int fails = 0;
  int cmp_count = 0;
  always #5 i_core_clk = ~i_core_clk;
  toc_compare_unit i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_tick(i_tick), .i_capture_event(i_capture_event), .i_irq_ack(i_irq_ack),
    .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .o_cmp_irq(irq), .o_pin_out(pin),
    .o_pin_oe_n(oe_n));
  toc_cpu_model i_cpu (.i_core_clk(i_core_clk), .o_address(adr), .o_read(rd_s),
    .o_write(wr_s), .o_writedata(wdat), .i_readdata(rdat), .i_waitrequest(wt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      i_tick <= 1'b1;
      @(posedge i_core_clk);
      i_tick <= 1'b0;
    end
  endtask
  // Pin is registered behind the bus commit
  task automatic pin_chk(input logic e);
    repeat (3) @(posedge i_core_clk);
    chk("pin0", {15'h0, e}, {15'h0, pin[0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("oe_n", 16'h0007, {13'h0, oe_n});
    chk("pin", 16'h0000, {13'h0, pin});
    i_cpu.rd(REG_FLAGS, q);
    chk("flags", 16'h0000, {8'h0, q});
    $display("test reset done");
  endtask
  task automatic t_match();
    i_cpu.wr16(REG_CMP_LO[0], REG_CMP_HI[0], 16'h0305);
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h0305);
    i_cpu.rd(REG_CAP_LO, q);
    i_cpu.rd(REG_CMP_HI[0], q);
    chk("cmp hi", 16'h0003, {8'h0, q});
    i_cpu.wr(REG_ACTION, 8'h01);
    i_cpu.wr(REG_PORT, 8'h01);
    ticks(1);
    i_cpu.rd(REG_FLAGS, q);
    chk("blocked flag", 16'h0000, {8'h0, q});
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h0304);
    ticks(2);
    i_cpu.rd(REG_FLAGS, q);
    chk("match flag", 16'h0001, {8'h0, q});
    pin_chk(1'b1);
    chk("oe_n0", 16'h0000, {15'h0, oe_n[0]});
    i_cpu.wr(REG_IRQ_EN, 8'h01);
    repeat (3) @(posedge i_core_clk);
    chk("irq", 16'h0001, {13'h0, irq});
    i_irq_ack <= 3'h1;
    @(posedge i_core_clk);
    i_irq_ack <= 3'h0;
    repeat (3) @(posedge i_core_clk);
    chk("irq ack", 16'h0000, {13'h0, irq});
    $display("test match done");
  endtask
  task automatic t_force();
    i_cpu.wr(REG_ACTION, 8'h02);
    i_cpu.wr(REG_FORCE, 8'h01);
    pin_chk(1'b0);
    i_cpu.rd(REG_FLAGS, q);
    chk("force flag", 16'h0000, {8'h0, q});
    i_cpu.wr(REG_ACTION, 8'h03);
    i_cpu.wr(REG_FORCE, 8'h01);
    pin_chk(1'b1);
    i_cpu.wr(REG_ACTION, 8'h00);
    i_cpu.wr(REG_FORCE, 8'h01);
    pin_chk(1'b0);
    i_cpu.wr(REG_ACTION, 8'h01);
    pin_chk(1'b1);
    i_cpu.wr(REG_MODE, {4'h0, MODE_FAST8});
    i_cpu.wr(REG_FORCE, 8'h01);
    i_cpu.wr(REG_MODE, {4'h0, MODE_NORMAL});
    pin_chk(1'b1);
    i_cpu.wr(REG_FORCE, 8'h01);
    pin_chk(1'b0);
    $display("test force done");
  endtask
  task automatic t_capture();
    i_cpu.wr(REG_ACTION, 8'h3f);
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h1234);
    @(posedge i_core_clk);
    i_capture_event <= 1'b1;
    @(posedge i_core_clk);
    i_capture_event <= 1'b0;
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h0abc);
    @(posedge i_core_clk);
    i_capture_event <= 1'b1;
    @(posedge i_core_clk);
    i_capture_event <= 1'b0;
    i_cpu.rd16(REG_CAP_LO, REG_CAP_HI, w);
    chk("capture", 16'h0abc, w);
    i_cpu.wr(REG_FLAGS, 8'h08);
    i_cpu.rd(REG_FLAGS, q);
    chk("cap flag", 16'h0000, {15'h0, q[FLAG_CAP_BIT]});
    $display("test capture done");
  endtask
  task automatic t_clear_on_match();
    i_cpu.wr(REG_MODE, {4'h0, MODE_CLEAR_A});
    i_cpu.wr16(REG_CMP_LO[0], REG_CMP_HI[0], 16'h0002);
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h0000);
    ticks(3);
    i_cpu.rd16(REG_CNT_LO, REG_CNT_HI, w);
    chk("clear count", 16'h0000, w);
    // Ticks with the enable low must leave the counter where it was
    i_ce <= 1'b0;
    ticks(2);
    i_ce <= 1'b1;
    i_cpu.rd16(REG_CNT_LO, REG_CNT_HI, w);
    chk("frozen count", 16'h0000, w);
    $display("test clear_on_match done");
  endtask
  task automatic t_buffer();
    i_cpu.wr(REG_MODE, {4'h0, MODE_FAST8});
    i_cpu.wr(REG_FLAGS, 8'h0f);
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h0010);
    i_cpu.wr16(REG_CMP_LO[1], REG_CMP_HI[1], 16'h0011);
    i_cpu.rd(REG_CMP_LO[1], q);
    chk("cmp buf", 16'h0011, {8'h0, q});
    ticks(2);
    i_cpu.rd(REG_FLAGS, q);
    chk("buffered flag", 16'h0000, {14'h0, q[1], 1'b0});
    // Wrap at TOP moves the buffer in; the match then comes 18 ticks after the wrap
    i_cpu.wr16(REG_CNT_LO, REG_CNT_HI, 16'h00fe);
    ticks(20);
    i_cpu.rd(REG_FLAGS, q);
    chk("loaded flag", 16'h0002, {14'h0, q[1], 1'b0});
    $display("test buffer done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    fails += i_cpu.hangs;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    t_reset();
    t_match();
    t_force();
    t_capture();
    t_clear_on_match();
    t_buffer();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
